// ### src/uart3_serial_port.sv
// third serial port: two reload timers, frame engine and register slave
// assumes synchronous pins, one clock, AXI4-Lite master keeping handshakes
// Functional notes
// - mode bit: 0 eight-bit, 1 nine-bit frames
// - bit rate is timer overflow rate over four
// - timer 2 reload overflow, optional divide twelve
// - timer 3 reload overflow, optional divide twelve
// - select bit: 0 timer 2, 1 timer 3
// - timer 2 is the reset default source
// - nine-bit filter needs ninth one and match
// - eight-bit filter needs stop bit and match
// - receive only while receive enable set
// - nine-bit transmit sends control ninth bit
// - nine-bit receive stores ninth bit
// - transmit done flag set at frame end
// - receive done flag set at mid-stop sample of an accepted frame
// - buffer write starts transmission at once
// - buffer read returns receive latch
// - timer 2 counts only when run set
// - eight-bit frame ten bits, stop stored
// - nine-bit frame eleven bits with ninth
// - interrupt needs port and global enable
module uart3_serial_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [uart3_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [uart3_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // port interrupt request
  output logic irq
);
  import uart3_pkg::*;

  // software registers
  ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] aux_reg, aux_next; // timer 2 run and bypass
  logic [7:0] t34_reg, t34_next; // timer 3 run and bypass
  logic [7:0] ie2_reg, ie2_next; // port interrupt enable
  logic [7:0] ie_reg, ie_next; // global interrupt enable
  logic [7:0] psw_reg, psw_next; // pin group switch, stored only
  logic [7:0] addr_reg, addr_next; // own address for filtering
  logic [7:0] mask_reg, mask_next; // care bits of own address
  logic [7:0] rx_latch_reg, rx_latch_next; // receive latch
  logic irq_reg, irq_next;
  // bus slave state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [9:0] awidx_reg, awidx_next; // held write index
  logic [7:0] wbyte_reg, wbyte_next; // held write byte
  logic wlane_reg, wlane_next; // low byte lane enabled
  // timer state, entry 0 is timer 2 and entry 1 timer 3
  logic [15:0] tcnt_reg [2];
  logic [15:0] tcnt_next [2];
  logic [15:0] trl_reg [2];
  logic [15:0] trl_next [2];
  logic [3:0] tpre_reg [2];
  logic [3:0] tpre_next [2];
  logic [1:0] t_run, t_byp, t_wr_hi, t_wr_lo, t_ovf;
  // transmitter state
  tx_state_t tx_state_reg, tx_state_next;
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_left_reg, tx_left_next;
  logic [1:0] tx_q_reg, tx_q_next;
  logic tx_out_reg, tx_out_next;
  // receiver state
  rx_state_t rx_state_reg, rx_state_next;
  logic [8:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [1:0] rx_q_reg, rx_q_next;
  // combinational helpers
  logic wr_go; // a full write is performed this cycle
  logic wr_buf; // software writes the data buffer
  logic sel_ovf; // overflow of the chosen baud timer
  logic tx_done; // last bit period just ended
  logic addr_match;
  rx_event_t rx_ev;

  assign wr_go = awready_reg == 1'b0 && wready_reg == 1'b0 &&
                 bvalid_reg == 1'b0;
  assign wr_buf = wr_go && wlane_reg &&
                  awidx_reg == IDX_UART3_DATA_BUFFER;
  assign t_run = {t34_reg[T34_TIMER3_RUN_POS],
                  aux_reg[AUX_TIMER2_RUN_POS]};
  assign t_byp = {t34_reg[T34_TIMER3_BYPASS_POS],
                  aux_reg[AUX_TIMER2_BYPASS_POS]};
  assign t_wr_hi = {wr_go && wlane_reg && awidx_reg == IDX_TIMER3_HIGH_BYTE,
                    wr_go && wlane_reg && awidx_reg == IDX_TIMER2_HIGH_BYTE};
  assign t_wr_lo = {wr_go && wlane_reg && awidx_reg == IDX_TIMER3_LOW_BYTE,
                    wr_go && wlane_reg && awidx_reg == IDX_TIMER2_LOW_BYTE};
  // reset clears the select bit, so timer 2 drives the baud
  assign sel_ovf = ctrl_reg.baud_timer_select ? t_ovf[1] : t_ovf[0];

  // two reload timers, each with its own optional divide by twelve
  for (genvar i = 0; i < 2; i++) begin : g_timer
    // overflow when a counting tick finds the counter full
    assign t_ovf[i] = t_run[i] && (t_byp[i] || tpre_reg[i] == PRESCALE_LAST)
                      && tcnt_reg[i] == TIMER_FULL;

    // next count, prescale and reload values
    always_comb begin
      tcnt_next[i] = tcnt_reg[i];
      trl_next[i] = trl_reg[i];
      tpre_next[i] = tpre_reg[i];
      if (t_run[i]) begin
        if (t_byp[i] || tpre_reg[i] == PRESCALE_LAST) begin
          tpre_next[i] = 4'h0;
          // reload gives 65536 minus reload counts per overflow
          tcnt_next[i] = (tcnt_reg[i] == TIMER_FULL) ? trl_reg[i]
                         : tcnt_reg[i] + 16'h0001;
        end else begin
          tpre_next[i] = tpre_reg[i] + 4'h1;
        end
      end
      // a byte write sets both the reload and the live count
      if (t_wr_hi[i]) begin
        trl_next[i][15:8] = wbyte_reg;
        tcnt_next[i][15:8] = wbyte_reg;
      end
      if (t_wr_lo[i]) begin
        trl_next[i][7:0] = wbyte_reg;
        tcnt_next[i][7:0] = wbyte_reg;
      end
    end

    // timer registers
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tcnt_reg[i] <= TIMER_RESET;
        trl_reg[i] <= TIMER_RESET;
        tpre_reg[i] <= 4'h0;
      end else begin
        tcnt_reg[i] <= tcnt_next[i];
        trl_reg[i] <= trl_next[i];
        tpre_reg[i] <= tpre_next[i];
      end
    end
  end

  // transmitter; restarts on any buffer write, even mid-frame
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_sh_next = tx_sh_reg;
    tx_left_next = tx_left_reg;
    tx_q_next = tx_q_reg;
    tx_done = 1'b0;
    if (wr_buf) begin
      tx_state_next = TX_BUSY;
      tx_q_next = 2'h0;
      if (ctrl_reg.frame_mode_select) begin
        // start, data lsb first, ninth, stop
        tx_sh_next = {1'b1, ctrl_reg.tx_ninth_bit, wbyte_reg, 1'b0};
        tx_left_next = FRAME9_BITS;
      end else begin
        tx_sh_next = {2'b11, wbyte_reg, 1'b0};
        tx_left_next = FRAME8_BITS;
      end
    end else if (tx_state_reg == TX_BUSY && sel_ovf) begin
      tx_q_next = tx_q_reg + 2'h1;
      if (tx_q_reg == OVF_PER_BIT_LAST) begin
        tx_sh_next = {1'b1, tx_sh_reg[10:1]};
        tx_left_next = tx_left_reg - 4'h1;
        if (tx_left_reg == 4'h1) begin
          tx_state_next = TX_IDLE;
          tx_done = 1'b1;
        end
      end
    end
    // line idles high; the start bit leaves with the write
    tx_out_next = (tx_state_next == TX_BUSY) ? tx_sh_next[0] : 1'b1;
  end

  // transmitter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      tx_q_reg <= 2'h0;
      tx_out_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_sh_reg <= tx_sh_next;
      tx_left_reg <= tx_left_next;
      tx_q_reg <= tx_q_next;
      tx_out_reg <= tx_out_next;
    end
  end

  // given address, or broadcast built from address or mask
  assign addr_match =
    (((rx_ev.data ^ addr_reg) & mask_reg) == 8'h00) ||
    (((rx_ev.data ^ (addr_reg | mask_reg)) & (addr_reg | mask_reg)) == 8'h00);

  // receiver, sampling four times per bit on the baud timer
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_q_next = rx_q_reg;
    rx_ev.data = ctrl_reg.frame_mode_select ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
    rx_ev.ninth = ctrl_reg.frame_mode_select ? rx_sh_reg[8] : serial_in_pin;
    rx_ev.accept = 1'b0;
    if (!ctrl_reg.receive_enable_bit) begin
      rx_state_next = RX_IDLE;
    end else if (sel_ovf) begin
      rx_q_next = rx_q_reg + 2'h1;
      case (rx_state_reg)
        RX_IDLE: begin
          if (!serial_in_pin) begin
            rx_state_next = RX_START;
            rx_q_next = 2'h0;
          end
        end
        RX_START: begin
          // glitch shorter than half a bit is dropped
          if (rx_q_reg == START_CHECK_Q) begin
            rx_state_next = serial_in_pin ? RX_IDLE : RX_DATA;
            rx_q_next = 2'h0;
            rx_cnt_next = 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_q_reg == OVF_PER_BIT_LAST) begin
            rx_sh_next = {serial_in_pin, rx_sh_reg[8:1]};
            rx_cnt_next = rx_cnt_reg + 4'h1;
            if (rx_cnt_next == (ctrl_reg.frame_mode_select ? DATA9_BITS
                                : DATA8_BITS)) begin
              rx_state_next = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_q_reg == OVF_PER_BIT_LAST) begin
            rx_state_next = RX_IDLE;
            // filter decides whether the frame is delivered
            if (!ctrl_reg.address_filter_enable) begin
              rx_ev.accept = 1'b1;
            end else if (ctrl_reg.frame_mode_select) begin
              rx_ev.accept = rx_sh_reg[8] && addr_match;
            end else begin
              rx_ev.accept = serial_in_pin && addr_match;
            end
          end
        end
        default: rx_state_next = RX_IDLE;
      endcase
    end
  end

  // receiver registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg <= 9'h000;
      rx_cnt_reg <= 4'h0;
      rx_q_reg <= 2'h0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_sh_reg <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_q_reg <= rx_q_next;
    end
  end

  // software registers; hardware sets win over software clears
  always_comb begin
    ctrl_next = ctrl_reg;
    aux_next = aux_reg;
    t34_next = t34_reg;
    ie2_next = ie2_reg;
    ie_next = ie_reg;
    psw_next = psw_reg;
    addr_next = addr_reg;
    mask_next = mask_reg;
    rx_latch_next = rx_latch_reg;
    if (wr_go && wlane_reg) begin
      case (awidx_reg)
        IDX_UART3_CONTROL: ctrl_next = ctrl_t'(wbyte_reg);
        IDX_AUX_CONTROL: aux_next = wbyte_reg;
        IDX_TIMER34_MODE_CONTROL: t34_next = wbyte_reg;
        IDX_IRQ_ENABLE_SECOND: ie2_next = wbyte_reg;
        IDX_IRQ_ENABLE_MAIN: ie_next = wbyte_reg;
        IDX_PERIPHERAL_SWITCH: psw_next = wbyte_reg;
        IDX_RX_ADDRESS: addr_next = wbyte_reg;
        IDX_RX_ADDRESS_MASK: mask_next = wbyte_reg;
        default: ;
      endcase
    end
    // flags only fall by a control write, never by buffer access
    if (tx_done) begin
      ctrl_next.tx_done_flag = 1'b1;
    end
    if (rx_ev.accept) begin
      ctrl_next.rx_done_flag = 1'b1;
      ctrl_next.rx_ninth_bit = rx_ev.ninth;
      rx_latch_next = rx_ev.data;
    end
    irq_next = ie2_reg[IE2_PORT_IRQ_POS] && ie_reg[IE_GLOBAL_IRQ_POS] &&
               (ctrl_reg.tx_done_flag || ctrl_reg.rx_done_flag);
  end

  // software register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ctrl_t'(RESET_BYTE);
      aux_reg <= RESET_BYTE;
      t34_reg <= RESET_BYTE;
      ie2_reg <= RESET_BYTE;
      ie_reg <= RESET_BYTE;
      psw_reg <= RESET_BYTE;
      addr_reg <= RESET_BYTE;
      mask_reg <= RESET_BYTE;
      rx_latch_reg <= RESET_BYTE;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      aux_reg <= aux_next;
      t34_reg <= t34_next;
      ie2_reg <= ie2_next;
      ie_reg <= ie_next;
      psw_reg <= psw_next;
      addr_reg <= addr_next;
      mask_reg <= mask_next;
      rx_latch_reg <= rx_latch_next;
      irq_reg <= irq_next;
    end
  end

  // bus slave: hold address and data, write when both are in
  always_comb begin
    logic [9:0] ridx;
    logic [7:0] rbyte;
    logic hit;
    ridx = s_axi_araddr[AXI_ADDR_W-1:2];
    rbyte = 8'h00;
    hit = 1'b1;
    awready_next = awready_reg;
    wready_next = wready_reg;
    awidx_next = awidx_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      awready_next = 1'b0;
      awidx_next = s_axi_awaddr[AXI_ADDR_W-1:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      wready_next = 1'b0;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (wr_go) begin
      bvalid_next = 1'b1;
      case (awidx_reg)
        IDX_AUX_CONTROL, IDX_UART3_CONTROL, IDX_UART3_DATA_BUFFER,
        IDX_IRQ_ENABLE_SECOND, IDX_IRQ_ENABLE_MAIN, IDX_PERIPHERAL_SWITCH,
        IDX_TIMER34_MODE_CONTROL, IDX_TIMER3_HIGH_BYTE, IDX_TIMER3_LOW_BYTE,
        IDX_TIMER2_HIGH_BYTE, IDX_TIMER2_LOW_BYTE, IDX_RX_ADDRESS,
        IDX_RX_ADDRESS_MASK: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    // read mux; the buffer address answers with the receive latch
    case (ridx)
      IDX_UART3_CONTROL: rbyte = ctrl_reg;
      IDX_UART3_DATA_BUFFER: rbyte = rx_latch_reg;
      IDX_AUX_CONTROL: rbyte = aux_reg;
      IDX_TIMER34_MODE_CONTROL: rbyte = t34_reg;
      IDX_IRQ_ENABLE_SECOND: rbyte = ie2_reg;
      IDX_IRQ_ENABLE_MAIN: rbyte = ie_reg;
      IDX_PERIPHERAL_SWITCH: rbyte = psw_reg;
      IDX_TIMER3_HIGH_BYTE: rbyte = tcnt_reg[1][15:8];
      IDX_TIMER3_LOW_BYTE: rbyte = tcnt_reg[1][7:0];
      IDX_TIMER2_HIGH_BYTE: rbyte = tcnt_reg[0][15:8];
      IDX_TIMER2_LOW_BYTE: rbyte = tcnt_reg[0][7:0];
      IDX_RX_ADDRESS: rbyte = addr_reg;
      IDX_RX_ADDRESS_MASK: rbyte = mask_reg;
      default: hit = 1'b0;
    endcase
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rbyte};
      rresp_next = hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  // bus slave flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awidx_reg <= 10'h000;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awidx_reg <= awidx_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign serial_out_pin = tx_out_reg;
  assign irq = irq_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tx_start_now: assert property (wr_buf |=> !serial_out_pin)
    else $error("start bit did not follow buffer write");
  a_tx_ninth_sent: assert property (wr_buf && ctrl_reg.frame_mode_select
    |=> tx_sh_reg[9] == $past(ctrl_reg.tx_ninth_bit))
    else $error("ninth transmit bit not loaded");
  a_done_sticky: assert property (ctrl_reg.tx_done_flag && !wr_go
    |=> ctrl_reg.tx_done_flag)
    else $error("transmit done flag cleared itself");
  a_tx_done_set: assert property (tx_done |=> ctrl_reg.tx_done_flag)
    else $error("transmit done flag not set");
  a_rx_disabled: assert property (!ctrl_reg.receive_enable_bit
    |=> rx_state_reg == RX_IDLE)
    else $error("receiver active while disabled");
  a_filter_nine: assert property (rx_ev.accept &&
    ctrl_reg.address_filter_enable && ctrl_reg.frame_mode_select
    |-> rx_sh_reg[8] && addr_match)
    else $error("nine-bit filter passed a data frame");
  a_filter_eight: assert property (rx_ev.accept &&
    ctrl_reg.address_filter_enable && !ctrl_reg.frame_mode_select
    |-> serial_in_pin && addr_match)
    else $error("eight-bit filter passed a bad frame");
  a_ninth_stored: assert property (rx_ev.accept && ctrl_reg.frame_mode_select
    |=> ctrl_reg.rx_ninth_bit == $past(rx_sh_reg[8]))
    else $error("received ninth bit not stored");
  a_t2_prescale: assert property (t_ovf[0] && !t_byp[0] && t_run[0]
    |=> !t_ovf[0] [*8])
    else $error("timer 2 divide by twelve broken");
  a_t3_prescale: assert property (t_ovf[1] && !t_byp[1] && t_run[1]
    |=> !t_ovf[1] [*8])
    else $error("timer 3 divide by twelve broken");
  a_t2_stopped: assert property (!t_run[0] && !t_wr_hi[0] && !t_wr_lo[0]
    |=> $stable(tcnt_reg[0]))
    else $error("timer 2 counted while stopped");
  a_irq_gated: assert property (irq |-> $past(ie2_reg[IE2_PORT_IRQ_POS]) &&
    $past(ie_reg[IE_GLOBAL_IRQ_POS]))
    else $error("interrupt without both enables");
  a_baud_source: assert property (tx_state_reg == TX_BUSY && !wr_buf &&
    !sel_ovf |=> $stable(tx_q_reg))
    else $error("bit timing moved without selected overflow");

  c_tx_frame: cover property (tx_done);
  c_rx_frame: cover property (rx_ev.accept);
  c_rx_filtered: cover property (ctrl_reg.address_filter_enable &&
    rx_state_reg == RX_STOP && sel_ovf && rx_q_reg == OVF_PER_BIT_LAST &&
    !rx_ev.accept);
  c_irq: cover property (irq);
endmodule : uart3_serial_port

// ### src/uart3_pkg.sv
// constants, field layouts and types for the third serial port block
// assumes one 125 MHz clock and a 32-bit AXI4-Lite register bus
package uart3_pkg;
  // system clock rate, kept for baud arithmetic by software
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned AXI_ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_AUX_CONTROL = 10'h08E;
  localparam logic [9:0] IDX_UART3_CONTROL = 10'h0AC;
  localparam logic [9:0] IDX_UART3_DATA_BUFFER = 10'h0AD;
  localparam logic [9:0] IDX_IRQ_ENABLE_SECOND = 10'h0AF;
  localparam logic [9:0] IDX_PERIPHERAL_SWITCH = 10'h0BA;
  localparam logic [9:0] IDX_TIMER34_MODE_CONTROL = 10'h0D1;
  localparam logic [9:0] IDX_TIMER3_HIGH_BYTE = 10'h0D4;
  localparam logic [9:0] IDX_TIMER3_LOW_BYTE = 10'h0D5;
  localparam logic [9:0] IDX_TIMER2_HIGH_BYTE = 10'h0D6;
  localparam logic [9:0] IDX_TIMER2_LOW_BYTE = 10'h0D7;
  localparam logic [9:0] IDX_IRQ_ENABLE_MAIN = 10'h0A8;
  localparam logic [9:0] IDX_RX_ADDRESS = 10'h0E0;
  localparam logic [9:0] IDX_RX_ADDRESS_MASK = 10'h0E1;
  // field positions
  localparam int unsigned AUX_TIMER2_RUN_POS = 4;
  localparam int unsigned AUX_TIMER2_BYPASS_POS = 2;
  localparam int unsigned T34_TIMER3_RUN_POS = 3;
  localparam int unsigned T34_TIMER3_BYPASS_POS = 1;
  localparam int unsigned IE2_PORT_IRQ_POS = 3;
  localparam int unsigned IE_GLOBAL_IRQ_POS = 7;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  // counting constants
  localparam logic [15:0] TIMER_FULL = 16'hFFFF;
  localparam logic [3:0] PRESCALE_LAST = 4'hB; // divide by 12
  localparam logic [1:0] OVF_PER_BIT_LAST = 2'h3; // four per bit
  localparam logic [1:0] START_CHECK_Q = 2'h1; // mid start bit
  localparam logic [3:0] FRAME8_BITS = 4'hA;
  localparam logic [3:0] FRAME9_BITS = 4'hB;
  localparam logic [3:0] DATA8_BITS = 4'h8;
  localparam logic [3:0] DATA9_BITS = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic frame_mode_select;
    logic baud_timer_select;
    logic address_filter_enable;
    logic receive_enable_bit;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } ctrl_t;
  // one received frame handed to the register group
  typedef struct packed {
    logic accept;
    logic [7:0] data;
    logic ninth;
  } rx_event_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_BUSY} tx_state_t;
endpackage : uart3_pkg

// ### verif/uart3_remote.sv
// remote transceiver driving the receive pin
// assumes the bench set 64 clocks per bit
module uart3_remote (
  // clock and line
  input wire logic aclk,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line = 1'b1; // idle high, as a pulled-up line
  // start, data lsb first, stop
  task automatic send(input logic [10:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      rx_line <= f[k];
      repeat (64) @(posedge aclk);
    end
    rx_line <= 1'b1; // back to idle, even after a low stop bit
  endtask : send
endmodule : uart3_remote

// ### verif/tb_uart3_serial_port.sv
// bench for the serial port: register bus master and line checks
// assumes reload 16'hFFF0 with bypass, so 64 clocks per bit
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_uart3_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  import uart3_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
  logic rvalid, sin, sout, irq;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$], x; // expected reads
  logic [15:0] sq[$], f; // expected frames, length on top
  logic [7:0] d, e;
  int mismatches = 0, compares = 0;
  uart3_serial_port dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_in_pin(sin),
    .serial_out_pin(sout), .irq(irq));
  uart3_remote remote (.aclk(aclk), .rx_line(sin));
  initial forever #4 aclk = ~aclk;
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // write cycle, each channel released once taken
  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    int n = 0;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && n < 99);
    bready <= 0;
    if (n >= 99) begin mismatches++; results(); end
    `CHK("bresp", RESP_OKAY, bresp)
  endtask : wr
  // read cycle; the monitor compares the answer
  task automatic rd(input logic [9:0] i, input logic [1:0] r,
      input logic [7:0] v);
    int n = 0;
    rq.push_back({r, 24'h0, v});
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (!rvalid && n < 99);
    rready <= 0;
    if (n >= 99) begin mismatches++; results(); end
  endtask : rd
  // send one byte and wait out the longest frame
  task automatic tx(input logic [7:0] v, input logic m, input logic b);
    sq.push_back(m ? {4'd11, 1'b0, 1'b1, b, v, 1'b0}
                   : {4'd10, 2'b0, 1'b1, v, 1'b0});
    wr(IDX_UART3_DATA_BUFFER, v);
    repeat (12 * 64) @(posedge aclk);
  endtask : tx
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      x = rq.pop_front();
      `CHK("rdata", x, {rresp, rdata})
    end
  end
  // mid-bit sampling from the start edge
  initial forever begin
    @(negedge sout);
    `CHK("tx_frame_due", 1'b1, sq.size() != 0)
    f = sq.pop_front();
    repeat (32) @(posedge aclk);
    for (int k = 0; k < f[15:12]; k++) begin
      `CHK("serial_bit", f[k], sout)
      repeat (64) @(posedge aclk);
    end
  end
  initial begin
    void'($urandom(32'h52433714));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(IDX_UART3_CONTROL, RESP_OKAY, 8'h00);
    rd(IDX_TIMER3_HIGH_BYTE, RESP_OKAY, 8'h00);
    rd(10'h3FF, RESP_SLVERR, 8'h00);
    $display("reset test done");
    wr(IDX_TIMER2_LOW_BYTE, 8'hF0);
    wr(IDX_TIMER2_HIGH_BYTE, 8'hFF);
    wr(IDX_AUX_CONTROL, 8'h14);
    wr(IDX_UART3_CONTROL, 8'h10);
    d = 8'($urandom);
    e = d ^ (8'($urandom) | 8'h01); // never equal to d
    tx(d, 0, 0);
    remote.send({2'b11, e, 1'b0}, 10);
    rd(IDX_UART3_DATA_BUFFER, RESP_OKAY, e);
    rd(IDX_UART3_CONTROL, RESP_OKAY, 8'h17);
    wr(IDX_UART3_CONTROL, 8'h00);
    remote.send({2'b11, d, 1'b0}, 10);
    rd(IDX_UART3_DATA_BUFFER, RESP_OKAY, e);
    wr(IDX_UART3_CONTROL, 8'h30);
    remote.send({2'b10, d, 1'b0}, 10);
    rd(IDX_UART3_CONTROL, RESP_OKAY, 8'h30);
    rd(IDX_UART3_DATA_BUFFER, RESP_OKAY, e);
    $display("eight-bit test done");
    wr(IDX_TIMER3_LOW_BYTE, 8'hF0);
    wr(IDX_TIMER3_HIGH_BYTE, 8'hFF);
    wr(IDX_TIMER34_MODE_CONTROL, 8'h0A);
    wr(IDX_UART3_CONTROL, 8'hD8);
    tx(e, 1, 1);
    wr(IDX_UART3_CONTROL, 8'hF0);
    remote.send({2'b10, d, 1'b0}, 11);
    rd(IDX_UART3_DATA_BUFFER, RESP_OKAY, e);
    remote.send({2'b11, d, 1'b0}, 11);
    rd(IDX_UART3_CONTROL, RESP_OKAY, 8'hF5);
    rd(IDX_UART3_DATA_BUFFER, RESP_OKAY, d);
    wr(IDX_IRQ_ENABLE_SECOND, 8'h08);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    wr(IDX_IRQ_ENABLE_MAIN, 8'h80);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    $display("nine-bit test done");
    `CHK("frames_left", 0, sq.size())
    `CHK("reads_left", 0, rq.size())
    results();
  end
endmodule : tb_uart3_serial_port
